// ---- core/rmac_top.sv ----
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
module rmac_top
    import rmac_pkg::*;
#(
    parameter int NUM_CHANNELS = MAX_CHANNELS,
    parameter int unsigned SCAN_CYC_5 = SCAN_NS_5 / CLK_PERIOD_NS,
    parameter int unsigned SCAN_CYC_12P5 = SCAN_NS_12P5 / CLK_PERIOD_NS,
    parameter int unsigned SCAN_CYC_15 = SCAN_NS_15 / CLK_PERIOD_NS,
    parameter int unsigned SCAN_CYC_25 = SCAN_NS_25 / CLK_PERIOD_NS,
    parameter int unsigned SCAN_CYC_30 = SCAN_NS_30 / CLK_PERIOD_NS,
    parameter int unsigned SCAN_CYC_100 = SCAN_NS_100 / CLK_PERIOD_NS
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic IRQ_O,
    // analog_input_subsystem side
    output logic [7:0] CHAN_SEL_O,
    output logic [7:0] MOD_SEL_O,
    output logic [7:0] GROUP_SEL_O,
    output logic [3:0] GAIN_O,
    output logic [14:0] DAC_DATA_O,
    output logic DAC_LOAD_O,
    output logic ADC_START_O,
    input wire logic COMP_LOW_I,
    input wire logic OVERRANGE_I,
    input wire logic ADC_DONE_I,
    input wire logic [11:0] ADC_DATA_I
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (NUM_CHANNELS < GROUP_SIZE || NUM_CHANNELS > MAX_CHANNELS ||
        NUM_CHANNELS % GROUP_SIZE != 0) begin : g_bad_chan
        $error("NUM_CHANNELS must be a multiple of 8 from 8 to 512");
    end
    if (SCAN_CYC_5 >= (1 << SCAN_CNT_W) || SCAN_CYC_100 < SETTLE_CYC) begin : g_bad_scan
        $error("scan period counts out of range");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [7:0] onehot8(input logic [2:0] idx);
        onehot8 = 8'h01 << idx;
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = strb[b] ? wd[8*b +: 8] : old[8*b +: 8];
        end
    endfunction
    function automatic logic [SCAN_CNT_W-1:0] scan_limit(input logic [2:0] rate);
        case (rate)
            3'h0: scan_limit = SCAN_CNT_W'(SCAN_CYC_5 - 1);
            3'h1: scan_limit = SCAN_CNT_W'(SCAN_CYC_12P5 - 1);
            3'h2: scan_limit = SCAN_CNT_W'(SCAN_CYC_15 - 1);
            3'h3: scan_limit = SCAN_CNT_W'(SCAN_CYC_25 - 1);
            3'h4: scan_limit = SCAN_CNT_W'(SCAN_CYC_30 - 1);
            default: scan_limit = SCAN_CNT_W'(SCAN_CYC_100 - 1);
        endcase
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [14:0] pins_s;
    logic comp_low_s, overrange_s, adc_done_s;
    logic [11:0] adc_data_s;
    rmac_sync #(.W(15)) u_sync (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .d_i({COMP_LOW_I, OVERRANGE_I, ADC_DONE_I, ADC_DATA_I}),
        .q_o(pins_s)
    );
    assign {comp_low_s, overrange_s, adc_done_s, adc_data_s} = pins_s;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rmac_state_type state_reg, state_next;
    rmac_cmd_type cmd_reg, cmd_next;
    rmac_result_type result_reg, result_next;
    logic [14:0] offset_reg, offset_next;
    logic [2:0] rate_reg, rate_next;
    logic done_reg, done_next, err_reg, err_next;
    logic sat_run_reg, sat_run_next, done_prev_reg, done_prev_next;
    logic [SCAN_CNT_W-1:0] pace_reg, pace_next;
    logic [15:0] settle_reg, settle_next;
    logic [3:0] gain_reg, gain_next;
    logic [7:0] chan_sel_reg, chan_sel_next;
    logic [7:0] mod_sel_reg, mod_sel_next;
    logic [7:0] group_sel_reg, group_sel_next;
    logic [14:0] dac_reg, dac_next;
    logic dac_load_reg, dac_load_next, start_reg, start_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic access, wr_cmd, rd_result, pace_tick;
    rmac_cmd_type wcmd;
    logic [4:0] gain_sum;
    logic [3:0] base_gain;
    // apb access phase: answered with one wait state
    assign access = PSEL_I && PENABLE_I && !pready_reg;
    assign wr_cmd = access && PWRITE_I && PADDR_I == CMD_OFS;
    assign rd_result = access && !PWRITE_I && PADDR_I == RESULT_OFS;
    assign wcmd = rmac_cmd_type'(CMD_W'(merge({17'h0, cmd_reg}, PWDATA_I, PSTRB_I)));
    assign pace_tick = pace_reg == '0;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    always_comb begin
        offset_next = offset_reg;
        rate_next = rate_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        pready_next = access;
        if (access) begin
            prdata_next = 32'h0000_0000;
            if (PWRITE_I) begin
                case (PADDR_I)
                    CMD_OFS, STATUS_OFS, RESULT_OFS: ; // command taken by the sequencer; status and result writes are ignored
                    OFFSET_OFS: offset_next =
                        15'(merge({17'h0, offset_reg}, PWDATA_I, PSTRB_I));
                    CONFIG_OFS: rate_next =
                        CFG_RATE_W'(merge({29'h0, rate_reg}, PWDATA_I, PSTRB_I));
                    default: pslverr_next = 1'b1;
                endcase
            end else begin
                case (PADDR_I)
                    CMD_OFS: prdata_next = {17'h0, cmd_reg};
                    OFFSET_OFS: prdata_next = {17'h0, offset_reg};
                    CONFIG_OFS: prdata_next = {29'h0, rate_reg};
                    STATUS_OFS: begin
                        prdata_next[ST_DONE_BIT] = done_reg;
                        prdata_next[ST_BUSY_BIT] = state_reg != S_IDLE;
                        prdata_next[ST_SAT_BIT] = result_reg.sat;
                        prdata_next[ST_ERR_BIT] = err_reg;
                    end
                    RESULT_OFS: prdata_next[RES_DONE_BIT:0] = {done_reg, result_reg};
                    default: pslverr_next = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            offset_reg <= OFFSET_RST;
            rate_reg <= RATE_RST;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            offset_reg <= offset_next;
            rate_reg <= rate_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    // starting gain: commanded, or unity when auto; suppression adds three binary steps
    always_comb begin
        base_gain = cmd_reg.autor ? 4'h0 :
            ((cmd_reg.gain > GAIN_MAX) ? GAIN_MAX : cmd_reg.gain);
        gain_sum = {1'b0, base_gain} + (cmd_reg.zsup ? ZSUP_STEPS : 5'h00);
    end
    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        result_next = result_reg;
        done_next = done_reg;
        err_next = err_reg;
        sat_run_next = sat_run_reg;
        done_prev_next = adc_done_s;
        settle_next = settle_reg;
        gain_next = gain_reg;
        chan_sel_next = chan_sel_reg;
        mod_sel_next = mod_sel_reg;
        group_sel_next = group_sel_reg;
        dac_next = dac_reg;
        dac_load_next = 1'b0;
        start_next = 1'b0;
        // free-running pacer, also gates when the relays may be switched
        pace_next = pace_tick ? scan_limit(rate_reg) : pace_reg - 1'b1;
        // a read clears availability; a completion in the same cycle wins
        if (rd_result) begin
            done_next = 1'b0;
        end
        case (state_reg)
            S_IDLE: begin
                if (wr_cmd) begin
                    err_next = int'(wcmd.addr) >= NUM_CHANNELS;
                    if (!err_next) begin
                        cmd_next = wcmd;
                        state_next = S_PACE;
                    end
                end
            end
            S_PACE: begin
                if (pace_tick) begin
                    chan_sel_next = onehot8(cmd_reg.addr[2:0]);
                    mod_sel_next = onehot8(cmd_reg.addr[5:3]);
                    group_sel_next = onehot8(cmd_reg.addr[8:6]);
                    gain_next = (gain_sum > {1'b0, GAIN_MAX}) ? GAIN_MAX : gain_sum[3:0];
                    if (cmd_reg.zsup) begin
                        dac_next = offset_reg;
                        dac_load_next = 1'b1;
                    end
                    settle_next = 16'(SETTLE_CYC - 1);
                    state_next = S_SETTLE;
                end
            end
            S_SETTLE: begin
                if (settle_reg == 16'h0000) begin
                    state_next = S_RANGE;
                end else begin
                    settle_next = settle_reg - 1'b1;
                end
            end
            S_RANGE: begin
                if (cmd_reg.autor && comp_low_s && gain_reg != GAIN_MAX) begin
                    gain_next = gain_reg + 1'b1;
                    settle_next = 16'(SETTLE_CYC - 1);
                    state_next = S_SETTLE;
                end else begin
                    start_next = 1'b1;
                    sat_run_next = 1'b0;
                    state_next = S_START;
                end
            end
            S_START: begin
                // wait for the converter to drop busy-done from any earlier run
                if (!adc_done_s) begin
                    state_next = S_CONVERT;
                end
                sat_run_next = sat_run_reg | overrange_s;
            end
            S_CONVERT: begin
                sat_run_next = sat_run_reg | overrange_s;
                if (adc_done_s && !done_prev_reg) begin
                    result_next.data = adc_data_s;
                    result_next.gain = gain_reg;
                    result_next.sat = sat_run_reg | overrange_s;
                    done_next = 1'b1;
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // sequencer registers, cleared by the synchronous reset
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state_reg <= S_IDLE;
            cmd_reg <= rmac_cmd_type'(CMD_RST);
            result_reg <= '0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            sat_run_reg <= 1'b0;
            done_prev_reg <= 1'b0;
            pace_reg <= '0;
            settle_reg <= 16'h0000;
            gain_reg <= 4'h0;
            chan_sel_reg <= 8'h00;
            mod_sel_reg <= 8'h00;
            group_sel_reg <= 8'h00;
            dac_reg <= 15'h0000;
            dac_load_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            result_reg <= result_next;
            done_reg <= done_next;
            err_reg <= err_next;
            sat_run_reg <= sat_run_next;
            done_prev_reg <= done_prev_next;
            pace_reg <= pace_next;
            settle_reg <= settle_next;
            gain_reg <= gain_next;
            chan_sel_reg <= chan_sel_next;
            mod_sel_reg <= mod_sel_next;
            group_sel_reg <= group_sel_next;
            dac_reg <= dac_next;
            dac_load_reg <= dac_load_next;
            start_reg <= start_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = pslverr_reg;
    assign IRQ_O = done_reg;
    assign CHAN_SEL_O = chan_sel_reg;
    assign MOD_SEL_O = mod_sel_reg;
    assign GROUP_SEL_O = group_sel_reg;
    assign GAIN_O = gain_reg;
    assign DAC_DATA_O = dac_reg;
    assign DAC_LOAD_O = dac_load_reg;
    assign ADC_START_O = start_reg;

endmodule

// ---- core/rmac_pkg.sv ----
package rmac_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    // gain-step settling before the comparator is trusted (least time)
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // scan periods per rate, 5 / 12.5 / 15 / 25 / 30 / 100 samples per second
    localparam int SCAN_NS_5 = 200000000;
    localparam int SCAN_NS_12P5 = 80000000;
    localparam int SCAN_NS_15 = 66666667;
    localparam int SCAN_NS_25 = 40000000;
    localparam int SCAN_NS_30 = 33333334;
    localparam int SCAN_NS_100 = 10000000;
    localparam int SCAN_CNT_W = 26;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] OFFSET_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] RESULT_OFS = 8'h0c;
    localparam logic [7:0] CONFIG_OFS = 8'h10;

    // command fields
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_GAIN_LSB = 9;
    localparam int CMD_AUTO_BIT = 13;
    localparam int CMD_ZSUP_BIT = 14;
    localparam int CMD_W = 15;
    // status fields
    localparam int ST_DONE_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_SAT_BIT = 2;
    localparam int ST_ERR_BIT = 3;
    // result fields
    localparam int RES_GAIN_LSB = 12;
    localparam int RES_SAT_BIT = 16;
    localparam int RES_DONE_BIT = 17;
    // config fields
    localparam int CFG_RATE_W = 3;

    // reset values
    localparam logic [14:0] CMD_RST = 15'h0000;
    localparam logic [14:0] OFFSET_RST = 15'h0000;
    localparam logic [2:0] RATE_RST = 3'h5;

    // ------------------------------------------------------------
    // gain and channel figures
    // ------------------------------------------------------------
    localparam logic [3:0] GAIN_MAX = 4'hb;
    localparam logic [4:0] ZSUP_STEPS = 5'h03;
    localparam int MAX_CHANNELS = 512;
    localparam int GROUP_SIZE = 8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic zsup;
        logic autor;
        logic [3:0] gain;
        logic [8:0] addr;
    } rmac_cmd_type;

    typedef struct packed {
        logic sat;
        logic [3:0] gain;
        logic [11:0] data;
    } rmac_result_type;

    typedef enum logic [2:0] {
        S_IDLE,
        S_PACE,
        S_SETTLE,
        S_RANGE,
        S_START,
        S_CONVERT
    } rmac_state_type;

endpackage

// ---- core/rmac_sync.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// three-stage pin synchroniser, change taken when stages 2 and 3 agree
// ------------------------------------------------------------
module rmac_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // per bit: only a value seen twice in a row passes, filters one-cycle glitches
    always_comb begin
        for (int i = 0; i < W; i++) begin
            q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule

// ---- sim/rmac_asserts.sv ----
`timescale 1ns/10ps
module rmac_asserts
    import rmac_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic IRQ_O,
    input wire logic [7:0] CHAN_SEL_O,
    input wire logic [7:0] MOD_SEL_O,
    input wire logic [7:0] GROUP_SEL_O,
    input wire logic [3:0] GAIN_O,
    input wire logic DAC_LOAD_O,
    input wire logic ADC_START_O,
    input wire logic ADC_DONE_I
);
    // ----------------------------------------
    // bus access steps and the relay select check
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    sequence s_take;
        PSEL_I && PENABLE_I && !PREADY_O;
    endsequence
    sequence s_res_read;
        PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && PADDR_I == RESULT_OFS;
    endsequence
    sequence s_sel_ok;
        ($onehot(CHAN_SEL_O) && $onehot(MOD_SEL_O) && $onehot(GROUP_SEL_O)) ||
            (CHAN_SEL_O == 8'h00 && MOD_SEL_O == 8'h00 && GROUP_SEL_O == 8'h00);
    endsequence
    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ready_wait: assert property (s_take |=> PREADY_O)
        else $error("ready missing after access");
    a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("slave error without ready");
    a_sel_onehot: assert property (s_sel_ok)
        else $error("relay selects not one-of-eight");
    a_gain_range: assert property (GAIN_O <= GAIN_MAX)
        else $error("gain code out of range");
    a_start_settled: assert property (ADC_START_O |-> GAIN_O == $past(GAIN_O, 390))
        else $error("conversion started before gain settled");
    a_start_pulse: assert property (ADC_START_O |=> !ADC_START_O)
        else $error("start longer than one cycle");
    a_load_pulse: assert property (DAC_LOAD_O |=> !DAC_LOAD_O)
        else $error("offset load longer than one cycle");
    a_irq_done: assert property ($rose(IRQ_O) |-> ADC_DONE_I)
        else $error("interrupt without finished conversion");
    a_irq_clear: assert property (s_res_read |=> !IRQ_O)
        else $error("interrupt kept after result read");
endmodule
bind rmac_top rmac_asserts u_chk (.*);

// ---- sim/rmac_ais_model.sv ----
`timescale 1ns/10ps
module rmac_subsys_model
    import rmac_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [3:0] gain_i,
    input wire logic [3:0] tgt_i,
    input wire logic sat_i,
    input wire logic [7:0] dly_i,
    input wire logic [11:0] data_i,
    output logic comp_low_o,
    output logic overrange_o,
    output logic done_o,
    output logic [11:0] data_o
);
    // ----------------------------------------
    // conversion timer
    // ----------------------------------------
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    // load on start, count down to the done edge
    always_comb begin
        cnt_next = cnt_reg;
        if (start_i) begin
            cnt_next = dly_i;
        end else if (cnt_reg != 8'h00) begin
            cnt_next = cnt_reg - 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    // ----------------------------------------
    // analog side answers
    // ----------------------------------------
    // comparator low until the wanted gain is reached
    assign comp_low_o = gain_i < tgt_i;
    assign overrange_o = sat_i && cnt_reg != 8'h00;
    assign done_o = cnt_reg == 8'h00;
    // inverted junk until shortly before done, never a stale value
    assign data_o = (cnt_reg < 8'h05) ? data_i : ~data_i;
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
    import rmac_pkg::*;
;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sat = 0, slv;
    logic pready, slv_o, irq, dac_load, adc_start, comp_low, ovr, adc_done;
    logic [7:0] paddr = 0, dly = 8'h10, chan_sel, mod_sel, grp_sel;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] gain, tgt = 0, pstrb = 4'hf;
    logic [14:0] dac_data, off;
    logic [11:0] adc_data, dat = 0;
    logic [15:0] rnd = 16'h0005;
    int err_total = 0, checks_done = 0, loads = 0;
    // ----------------------------------------
    // clock, design, far side
    // ----------------------------------------
    initial begin
        forever #2.5 clk = ~clk;
    end
    // short pacer so a scan fits the run
    // rates 5 and 12.5 keep long defaults: they must never be set across a pacer tick
    rmac_top #(.NUM_CHANNELS(504),
        .SCAN_CYC_15(500), .SCAN_CYC_25(500), .SCAN_CYC_30(500), .SCAN_CYC_100(500)) dut (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(slv_o), .IRQ_O(irq),
        .CHAN_SEL_O(chan_sel), .MOD_SEL_O(mod_sel), .GROUP_SEL_O(grp_sel), .GAIN_O(gain),
        .DAC_DATA_O(dac_data), .DAC_LOAD_O(dac_load), .ADC_START_O(adc_start),
        .COMP_LOW_I(comp_low), .OVERRANGE_I(ovr), .ADC_DONE_I(adc_done),
        .ADC_DATA_I(adc_data));
    rmac_subsys_model far (.clk_i(clk), .rst_n_i(rst_n), .start_i(adc_start), .gain_i(gain),
        .tgt_i(tgt), .sat_i(sat), .dly_i(dly), .data_i(dat), .comp_low_o(comp_low),
        .overrange_o(ovr), .done_o(adc_done), .data_o(adc_data));
    always @(posedge clk) begin
        if (dac_load === 1'b1) loads <= loads + 1;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // gain the block should settle on
    function automatic logic [3:0] egain(input rmac_cmd_type c, input logic [3:0] t);
        logic [4:0] g;
        g = c.autor ? {1'b0, t} : {1'b0, c.gain} + (c.zsup ? ZSUP_STEPS : 5'h00);
        return (g > {1'b0, GAIN_MAX}) ? GAIN_MAX : g[3:0];
    endfunction
    task automatic conclude();
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; an idle edge first so strobes never toggle twice
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        slv = slv_o;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_total++;
            conclude();
        end
    endtask
    // full conversion: command, wait, status, result
    task automatic conv(input rmac_cmd_type c, input logic [3:0] eg);
        int n;
        rnd = lfsr(rnd);
        dat <= rnd[11:0];
        dly <= {3'h0, rnd[15:12], 1'b1} + 8'h08;
        apb(1'b1, CMD_OFS, {17'h0, c});
        pwdata <= ~pwdata; // idle bus junk must not steer the gain
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < 9000);
        if (n >= 9000) begin
            err_total++;
            conclude();
        end
        chk(chan_sel, 8'h01 << c.addr[2:0]);
        chk(mod_sel, 8'h01 << c.addr[5:3]);
        chk(grp_sel, 8'h01 << c.addr[8:6]);
        chk(gain, eg);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd[2:0], {sat, 2'b01});
        apb(1'b0, RESULT_OFS, 32'h0);
        chk(rd[17:0], {1'b1, sat, eg, dat});
        chk(irq, 1'b0);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd[0], 1'b0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        int i;
        int k;
        rmac_cmd_type c;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, CONFIG_OFS, 32'h0);
        chk(rd[2:0], RATE_RST);
        apb(1'b0, CMD_OFS, 32'h0);
        chk(rd[14:0], CMD_RST);
        apb(1'b0, OFFSET_OFS, 32'h0);
        chk(rd[14:0], OFFSET_RST);
        apb(1'b0, 8'h14, 32'h0);
        chk(slv, 1'b1);
        // scan rate codes 0 to 5, last one left at 100 per second
        for (i = 0; i < 6; i++) begin
            apb(1'b1, CONFIG_OFS, i);
            apb(1'b0, CONFIG_OFS, 32'h0);
            chk(rd[2:0], i[2:0]);
        end
        // no byte enabled: the rate keeps the last code
        pstrb <= 4'h0;
        apb(1'b1, CONFIG_OFS, 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, CONFIG_OFS, 32'h0);
        chk(rd[2:0], 3'h5);
        // programmed gain, random channel and sample
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            c = rnd[14:0];
            c.autor = 1'b0;
            c.zsup = 1'b0;
            if (c.addr >= 9'd504) c.addr = c.addr - 9'd8;
            conv(c, egain(c, 4'h0));
        end
        // auto-ranging: commanded gain ignored, stops at target or top
        for (i = 0; i < 3; i++) begin
            tgt <= 4'(i * 7);
            c = {2'b01, 4'h7, 9'h1f7};
            conv(c, egain(c, 4'(i * 7)));
        end
        tgt <= 4'h0;
        // offset loaded, gain raised by three, capped at the top
        for (i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            off = rnd[14:0];
            apb(1'b1, OFFSET_OFS, {17'h0, off});
            c = {2'b10, 4'(i * 7 + 2), 9'h000};
            k = loads;
            conv(c, egain(c, 4'h0));
            chk(dac_data, off);
            chk(loads - k, 1);
        end
        sat <= 1'b1;
        conv(15'h0042, 4'h0);
        sat <= 1'b0;
        // first channel past the fitted range
        apb(1'b1, CMD_OFS, 32'h0000_01f8);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk({rd[3], rd[1:0]}, 3'b100);
        conclude();
    end
endmodule
